//--- rtl/sciu_pkg.sv
// Purpose: Shared constants for the serial receive status block
// Assumes: 32-bit APB, one word per register
// Notes: Bit positions index the register images and the 11-bit receive word
package sciu_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_STATUS_ONE = 5'h00;
    localparam logic [4:0] OFS_STATUS_TWO = 5'h04;
    localparam logic [4:0] OFS_DATA = 5'h08;
    localparam logic [4:0] OFS_CONTROL = 5'h0c;
    localparam logic [4:0] OFS_BAUD = 5'h10;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int S1_FULL = 5;
    localparam int S1_IDLE = 4;
    localparam int S1_OVERRUN = 3;
    localparam int S1_FRAME = 1;
    localparam int S1_PARITY = 0;
    localparam int S2_BREAK = 7;
    localparam int S2_EDGE = 6;
    localparam int S2_UNUSED = 5;
    localparam int S2_INVERT = 4;
    localparam int S2_WAKE_IDLE = 3;
    localparam int S2_LONG_BRK = 2;
    localparam int S2_LIN_DET = 1;
    localparam int S2_ACTIVE = 0;
    localparam int C_PARITY_EN = 0;
    localparam int C_PARITY_ODD = 1;
    localparam int C_NINE_BIT = 2;
    localparam int C_STANDBY = 3;
    localparam int C_SEND_BREAK = 4;
    localparam int W_FRAME_ERR = 9;
    localparam int W_PARITY_ERR = 10;
    localparam int WORD_W = 11;
    // ----------------------------------------
    // Reset values and bit-time counts
    // ----------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [15:0] BAUD_RESET = 16'h0010;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] CHAR_BITS = 4'ha;
    localparam logic [3:0] BRK_TX_SHORT = 4'ha;
    localparam logic [3:0] BRK_TX_LONG = 4'hd;
    localparam logic [3:0] BRK_DET_SHORT = 4'ha;
    localparam logic [3:0] BRK_DET_LIN = 4'hb;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sciu_rx_state_t;
endpackage : sciu_pkg

//--- rtl/sciu_buf.sv
// Purpose: Two-entry buffer between receive shifter and data register
// Assumes: Single clock, valid and ready on both sides
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
module sciu_buf #(
    parameter int WIDTH = sciu_pkg::WORD_W,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sciu_pkg::*;
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W:0] CNT_ONE = (PTR_W + 1)'(1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PTR_W:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != CNT_FULL);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push)
            next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
        if (pop)
            next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
        if (push && !pop)
            next_count = count + CNT_ONE;
        else if (pop && !push)
            next_count = count - CNT_ONE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                mem[i] <= '0;
            else if (push && wr_ptr == PTR_W'(i))
                mem[i] <= in_data;
        end
    end
endmodule : sciu_buf

//--- rtl/sciu_top.sv
// Purpose: Serial receive status, break detect and break send over APB
// Assumes: rxd synchronous to pclk, baud_div clocks per bit
// Notes: Zero-wait APB slave, unmapped address answers pslverr
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
// Function
// RULE1: Frame error set with full on zero stop
// RULE2: Frame error clears by status then data read
// RULE3: Parity error set with full on mismatch
// RULE4: Parity error clears by status then data read
// RULE5: Break flag set under LIN detect, write-one clears
// RULE6: Edge flag on active receive edge, write-one clears
// RULE7: Receive inversion applies to every sampled level
// RULE8: Standby idle sets idle flag only if enabled
// RULE9: Sent break lasts 10/11 or 13/14 bit times
// RULE10: Frame error ignores long break select
// RULE11: Break threshold 10/11, LIN detect 11/12 bits
// RULE12: LIN detect blocks frame error and full flags
// RULE13: Active flag set on start, cleared on idle
// RULE14: Software enables LIN detect with internal oscillator
// RULE15: Full set on load, cleared by status then data
// RULE16: Idle flag after full character of high line
// RULE17: Status two bit five reads zero, ignores writes
module sciu_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [sciu_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    input wire logic rxd,
    output logic txd
);
    import sciu_pkg::*;
    logic rd_acc, wr_acc, hit_s1, hit_s2, hit_data, hit_ctrl, hit_baud, mapped;
    logic [7:0] status_one, status_two, arm, next_status_one, next_status_two, next_arm;
    logic [3:0] ctrl, next_ctrl;
    logic [15:0] baud_div, next_baud;
    logic [8:0] data_reg, next_data;
    logic idle_armed, next_idle_armed;
    logic rx_line, rx_prev, pin_prev, edge_evt, bit_done, idle_evt, brk_evt;
    logic [15:0] lvl_cnt, next_lvl_cnt;
    logic [3:0] hi_bits, lo_bits, next_hi_bits, next_lo_bits;
    logic [3:0] char_bits, det_thr, nbits, tx_len;
    sciu_rx_state_t rx_state, next_rx_state;
    logic [15:0] rx_cnt, next_rx_cnt;
    logic [3:0] bit_idx, next_bit_idx;
    logic [8:0] shift, next_shift;
    logic start_ok, frame_done, push, load, buf_in_ready, buf_out_valid;
    logic [WORD_W-1:0] rx_word, buf_word;
    logic tx_brk, next_tx_brk;
    logic [15:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_bits, next_tx_bits;
    logic [31:0] low_run;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign rd_acc = psel && penable && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        hit_s1 = 1'b0;
        hit_s2 = 1'b0;
        hit_data = 1'b0;
        hit_ctrl = 1'b0;
        hit_baud = 1'b0;
        if (paddr == OFS_STATUS_ONE)
            hit_s1 = 1'b1;
        else if (paddr == OFS_STATUS_TWO)
            hit_s2 = 1'b1;
        else if (paddr == OFS_DATA)
            hit_data = 1'b1;
        else if (paddr == OFS_CONTROL)
            hit_ctrl = 1'b1;
        else if (paddr == OFS_BAUD)
            hit_baud = 1'b1;
        mapped = hit_s1 || hit_s2 || hit_data || hit_ctrl || hit_baud;
    end

    always_comb
    begin
        prdata = '0;
        if (hit_s1)
            prdata[7:0] = status_one;
        else if (hit_s2)
            prdata[7:0] = status_two;
        else if (hit_data)
            prdata[8:0] = data_reg;
        else if (hit_ctrl)
            prdata[4:0] = {tx_brk, ctrl};
        else if (hit_baud)
            prdata[15:0] = baud_div;
    end

    // ----------------------------------------
    // Registers and flags
    // ----------------------------------------
    assign nbits = DATA_BITS + {3'b0, ctrl[C_NINE_BIT]};
    assign char_bits = CHAR_BITS + {3'b0, ctrl[C_NINE_BIT]};
    assign load = buf_out_valid && !status_one[S1_FULL] && !status_two[S2_LIN_DET]; // RULE12

    always_comb
    begin
        next_status_one = status_one;
        next_status_two = status_two;
        next_ctrl = ctrl;
        next_baud = baud_div;
        next_arm = arm;
        next_data = data_reg;
        next_idle_armed = idle_armed;
        if (rd_acc && hit_s1)
            next_arm = status_one; // RULE2
        if (rd_acc && hit_data)
        begin
            next_status_one = status_one & ~arm; // RULE4
            next_arm = '0;
        end
        if (wr_acc && hit_s2)
        begin
            next_status_two[S2_BREAK] = status_two[S2_BREAK] & ~pwdata[S2_BREAK]; // RULE5
            next_status_two[S2_EDGE] = status_two[S2_EDGE] & ~pwdata[S2_EDGE]; // RULE6
            next_status_two[S2_INVERT:S2_LIN_DET] = pwdata[S2_INVERT:S2_LIN_DET]; // RULE17
        end
        if (wr_acc && hit_ctrl)
            next_ctrl = pwdata[C_STANDBY:C_PARITY_EN];
        if (wr_acc && hit_baud)
            next_baud = pwdata[15:0];
        if (idle_evt)
        begin
            next_status_two[S2_ACTIVE] = 1'b0; // RULE13
            next_ctrl[C_STANDBY] = 1'b0;
            next_idle_armed = 1'b0;
            if (idle_armed && (!ctrl[C_STANDBY] || status_two[S2_WAKE_IDLE]))
                next_status_one[S1_IDLE] = 1'b1; // RULE8 RULE16
        end
        if (start_ok)
            next_status_two[S2_ACTIVE] = 1'b1; // RULE13
        if (edge_evt)
            next_status_two[S2_EDGE] = 1'b1; // RULE6
        if (brk_evt && status_two[S2_LIN_DET])
            next_status_two[S2_BREAK] = 1'b1; // RULE5
        if (push && !buf_in_ready)
            next_status_one[S1_OVERRUN] = 1'b1;
        if (load)
        begin
            next_status_one[S1_FULL] = 1'b1; // RULE15
            next_status_one[S1_FRAME] = buf_word[W_FRAME_ERR]; // RULE1
            next_status_one[S1_PARITY] = buf_word[W_PARITY_ERR]; // RULE3
            next_data = buf_word[8:0];
            next_idle_armed = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_one <= STATUS_RESET;
            status_two <= STATUS_RESET;
            ctrl <= CONTROL_RESET;
            baud_div <= BAUD_RESET;
            arm <= STATUS_RESET;
            data_reg <= '0;
            idle_armed <= 1'b0;
        end
        else
        begin
            status_one <= next_status_one;
            status_two <= next_status_two;
            ctrl <= next_ctrl;
            baud_div <= next_baud;
            arm <= next_arm;
            data_reg <= next_data;
            idle_armed <= next_idle_armed;
        end
    end

    // ----------------------------------------
    // Line level timer
    // ----------------------------------------
    assign rx_line = rxd ^ status_two[S2_INVERT]; // RULE7
    assign edge_evt = status_two[S2_INVERT] ? (!pin_prev && rxd) : (pin_prev && !rxd); // RULE6
    assign det_thr = (status_two[S2_LIN_DET] ? BRK_DET_LIN : BRK_DET_SHORT)
        + {3'b0, ctrl[C_NINE_BIT]}; // RULE11
    assign bit_done = (rx_line == rx_prev) && (lvl_cnt == baud_div - 16'h0001);
    assign idle_evt = bit_done && rx_line && (hi_bits == char_bits - 4'h1); // RULE16
    assign brk_evt = bit_done && !rx_line && (lo_bits == det_thr - 4'h1); // RULE11

    always_comb
    begin
        next_lvl_cnt = lvl_cnt + 16'h0001;
        next_hi_bits = hi_bits;
        next_lo_bits = lo_bits;
        if (rx_line != rx_prev)
        begin
            next_lvl_cnt = '0;
            next_hi_bits = '0;
            next_lo_bits = '0;
        end
        else if (bit_done)
        begin
            next_lvl_cnt = '0;
            if (rx_line && hi_bits != 4'hf)
                next_hi_bits = hi_bits + 4'h1;
            if (!rx_line && lo_bits != 4'hf)
                next_lo_bits = lo_bits + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_prev <= 1'b1;
            pin_prev <= 1'b1;
            lvl_cnt <= '0;
            hi_bits <= 4'hf;
            lo_bits <= '0;
        end
        else
        begin
            rx_prev <= rx_line;
            pin_prev <= rxd;
            lvl_cnt <= next_lvl_cnt;
            hi_bits <= next_hi_bits;
            lo_bits <= next_lo_bits;
        end
    end

    // ----------------------------------------
    // Receive frame
    // ----------------------------------------
    assign rx_word = {ctrl[C_PARITY_EN] && ((^shift) != ctrl[C_PARITY_ODD]), // RULE3
        !rx_line, shift}; // RULE1 RULE10
    assign push = frame_done && !ctrl[C_STANDBY] && !status_two[S2_LIN_DET]; // RULE12

    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt + 16'h0001;
        next_bit_idx = bit_idx;
        next_shift = shift;
        start_ok = 1'b0;
        frame_done = 1'b0;
        case (rx_state)
            RX_IDLE:
            begin
                next_rx_cnt = '0;
                if (rx_prev && !rx_line)
                    next_rx_state = RX_START;
            end
            RX_START:
                if (rx_cnt == {1'b0, baud_div[15:1]})
                begin
                    next_rx_cnt = '0;
                    next_bit_idx = '0;
                    next_shift = '0;
                    if (rx_line)
                        next_rx_state = RX_IDLE;
                    else
                    begin
                        start_ok = 1'b1; // RULE13
                        next_rx_state = RX_DATA;
                    end
                end
            RX_DATA:
                if (rx_cnt == baud_div - 16'h0001)
                begin
                    next_rx_cnt = '0;
                    next_shift[bit_idx] = rx_line;
                    next_bit_idx = bit_idx + 4'h1;
                    if (bit_idx == nbits - 4'h1)
                        next_rx_state = RX_STOP;
                end
            RX_STOP:
                if (rx_cnt == baud_div - 16'h0001)
                begin
                    frame_done = 1'b1;
                    next_rx_state = RX_IDLE;
                end
            default:
                next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            bit_idx <= '0;
            shift <= '0;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            bit_idx <= next_bit_idx;
            shift <= next_shift;
        end
    end

    sciu_buf u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(rx_word),
        .out_valid(buf_out_valid),
        .out_ready(!status_one[S1_FULL] && !status_two[S2_LIN_DET]),
        .out_data(buf_word)
    );

    // ----------------------------------------
    // Break transmit
    // ----------------------------------------
    assign tx_len = (status_two[S2_LONG_BRK] ? BRK_TX_LONG : BRK_TX_SHORT)
        + {3'b0, ctrl[C_NINE_BIT]}; // RULE9

    always_comb
    begin
        next_tx_brk = tx_brk;
        next_tx_cnt = tx_cnt + 16'h0001;
        next_tx_bits = tx_bits;
        if (!tx_brk)
        begin
            next_tx_cnt = '0;
            next_tx_bits = '0;
            if (wr_acc && hit_ctrl && pwdata[C_SEND_BREAK])
                next_tx_brk = 1'b1;
        end
        else if (tx_cnt == baud_div - 16'h0001)
        begin
            next_tx_cnt = '0;
            next_tx_bits = tx_bits + 4'h1;
            if (tx_bits == tx_len - 4'h1)
                next_tx_brk = 1'b0; // RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_brk <= 1'b0;
            tx_cnt <= '0;
            tx_bits <= '0;
            txd <= 1'b1;
        end
        else
        begin
            tx_brk <= next_tx_brk;
            tx_cnt <= next_tx_cnt;
            tx_bits <= next_tx_bits;
            txd <= !next_tx_brk;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_run <= '0;
        else
            low_run <= txd ? 32'h0 : low_run + 32'h1;
    end

    a_frame_with_full: // RULE1
        assert property ($rose(status_one[S1_FRAME]) |-> $rose(status_one[S1_FULL]))
        else $error("frame error rose without full");
    a_frame_clear_seq: // RULE2
        assert property ($fell(status_one[S1_FRAME]) |-> $past(rd_acc && hit_data && arm[S1_FRAME]))
        else $error("frame error cleared out of sequence");
    a_parity_with_full: // RULE3
        assert property ($rose(status_one[S1_PARITY]) |-> $rose(status_one[S1_FULL]))
        else $error("parity error rose without full");
    a_parity_clear_seq: // RULE4
        assert property ($fell(status_one[S1_PARITY]) |-> $past(rd_acc && hit_data && arm[S1_PARITY]))
        else $error("parity error cleared out of sequence");
    a_break_flag_clear: // RULE5
        assert property ($fell(status_two[S2_BREAK]) |-> $past(wr_acc && hit_s2 && pwdata[S2_BREAK]))
        else $error("break flag cleared without write one");
    a_edge_falling_set: // RULE6
        assert property ($fell(rxd) && !status_two[S2_INVERT] && $past(!status_two[S2_INVERT])
            |=> status_two[S2_EDGE])
        else $error("falling edge did not set edge flag");
    a_edge_inverted_set: // RULE7
        assert property ($rose(rxd) && status_two[S2_INVERT] && $past(status_two[S2_INVERT])
            |=> status_two[S2_EDGE])
        else $error("inverted rising edge did not set edge flag");
    a_idle_in_standby: // RULE8
        assert property ($rose(status_one[S1_IDLE])
            |-> !$past(ctrl[C_STANDBY]) || $past(status_two[S2_WAKE_IDLE]))
        else $error("idle flag set in standby while disabled");
    a_break_send_len: // RULE9
        assert property ($rose(txd) |-> low_run == 32'(baud_div) * 32'(tx_len))
        else $error("sent break length wrong");
    a_frame_stop_high: // RULE10
        assert property (frame_done && rx_line |-> !rx_word[W_FRAME_ERR])
        else $error("frame error on high stop bit");
    a_break_threshold: // RULE11
        assert property ($rose(status_two[S2_BREAK])
            |-> $past(lo_bits) == BRK_DET_LIN + {3'b0, $past(ctrl[C_NINE_BIT])} - 4'h1)
        else $error("break detected at wrong length");
    a_lin_blocks_full: // RULE12
        assert property (status_two[S2_LIN_DET] && $past(status_two[S2_LIN_DET])
            |-> !$rose(status_one[S1_FULL]) && !$rose(status_one[S1_FRAME]))
        else $error("full or frame error set under LIN detect");
    a_active_on_start: // RULE13
        assert property (start_ok |=> status_two[S2_ACTIVE] [*1] ##0 !$stable(rx_state))
        else $error("active flag not set on start");
    a_active_off_idle: // RULE13
        assert property (idle_evt |=> !status_two[S2_ACTIVE])
        else $error("active flag not cleared on idle");
    a_full_clear_seq: // RULE15
        assert property ($fell(status_one[S1_FULL]) |-> $past(rd_acc && hit_data && arm[S1_FULL]))
        else $error("full flag cleared out of sequence");
    a_idle_char_time: // RULE16
        assert property ($rose(status_one[S1_IDLE])
            |-> $past(hi_bits) == CHAR_BITS + {3'b0, $past(ctrl[C_NINE_BIT])} - 4'h1)
        else $error("idle flag at wrong line time");
    a_unused_bit_zero: // RULE17
        assert property (rd_acc && hit_s2 |-> prdata[S2_UNUSED] == 1'b0)
        else $error("unused status bit reads one");

    c_frame_error: cover property ($rose(status_one[S1_FRAME]));
    c_lin_break: cover property ($rose(status_two[S2_BREAK]));
    c_overrun: cover property ($rose(status_one[S1_OVERRUN]));
    c_break_sent: cover property ($rose(txd));
endmodule : sciu_top

//--- tb/sciu_node.sv
// Purpose: Remote serial node on rxd and txd
// Assumes: Eight pclk cycles per bit
// Notes: Keeps the low time of the last break on txd
`timescale 1ns/1ps
module sciu_node (
    // Serial link
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    int brk_len = 0;
    int low_run = 0;
    initial rxd = 1'b1;
    // Send n bits LSB first; the line holds the last level afterwards
    task automatic send(input logic [15:0] bits, input int n, input logic inv);
        for (int i = 0; i < n; i++)
        begin
            rxd <= bits[i] ^ inv;
            repeat (8) @(posedge pclk);
        end
    endtask : send
    // Measure each low period on txd
    always @(posedge pclk)
    begin
        if (!txd)
            low_run <= low_run + 1;
        else if (low_run != 0)
        begin
            brk_len <= low_run;
            low_run <= 0;
        end
    end
endmodule : sciu_node

//--- tb/sciu_top_bench.sv
// Purpose: Register and serial tests of the receive status block
// Assumes: Baud divisor 8, zero-wait APB
// Notes: Masks hide flags that may race with idle detection
`timescale 1ns/1ps
module sciu_top_bench;
    import sciu_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [4:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, rxd, txd, err;
    int fail_count = 0, compares = 0;
    sciu_top i_sciu_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .rxd, .txd);
    sciu_node i_sciu_node (.pclk, .txd, .rxd);
    initial forever #2.5 pclk = ~pclk;
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic apb(input logic [4:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            $display("ERROR pready expected 1 seen %b", pready);
            end_sim();
        end
        @(posedge pclk);
    endtask : apb
    task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(a, 1'b0, 32'h0);
        compares++;
        if ((q & m) !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, q & m);
        end
    endtask : rc
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("s1", OFS_STATUS_ONE, 32'h0, '1);
        rc("s2", OFS_STATUS_TWO, 32'h0, '1);
        rc("baud", OFS_BAUD, 32'h10, '1);
        wr(OFS_BAUD, 32'h8);
        wr(OFS_STATUS_TWO, 32'h20);
        rc("unused", OFS_STATUS_TWO, 32'h0, '1);
        apb(5'h14, 1'b0, 32'h0);
        compares++;
        if (err !== 1'b1)
        begin
            fail_count++;
            $display("ERROR pslverr expected 1 seen %b", err);
        end
        // ----------------------------------------
        // Receive flags
        // ----------------------------------------
        i_sciu_node.send({6'h3f, 1'b1, 8'ha5, 1'b0}, 10, 1'b0);
        rc("full", OFS_STATUS_ONE, 32'h20, '1);
        rc("data", OFS_DATA, 32'ha5, '1);
        rc("active", OFS_STATUS_TWO, 32'h41, '1);
        rc("full_clr", OFS_STATUS_ONE, 32'h0, '1);
        repeat (100) @(posedge pclk);
        rc("idle", OFS_STATUS_ONE, 32'h10, '1);
        rc("inactive", OFS_STATUS_TWO, 32'h40, '1);
        wr(OFS_STATUS_TWO, 32'h40);
        rc("edge_clr", OFS_STATUS_TWO, 32'h0, '1);
        rc("idle_clr", OFS_DATA, 32'ha5, '1);
        i_sciu_node.send({5'h1f, 1'b1, 1'b0, 8'h3c, 1'b0}, 11, 1'b0);
        rc("frame_data", OFS_DATA, 32'h3c, 32'hff);
        rc("frame_kept", OFS_STATUS_ONE, 32'h22, 32'h3f);
        rc("frame_data", OFS_DATA, 32'h3c, 32'hff);
        rc("frame_clr", OFS_STATUS_ONE, 32'h0, 32'h2f);
        wr(OFS_CONTROL, 32'h1);
        i_sciu_node.send({7'h7f, 1'b1, 1'b0, 7'h01, 1'b0}, 10, 1'b0);
        rc("par_set", OFS_STATUS_ONE, 32'h21, 32'h23);
        rc("par_data", OFS_DATA, 32'h01, 32'h7f);
        rc("par_clr", OFS_STATUS_ONE, 32'h0, 32'h23);
        wr(OFS_CONTROL, 32'h8);
        repeat (70) @(posedge pclk);
        rc("standby_idle", OFS_STATUS_ONE, 32'h0, 32'h10);
        rc("standby_clr", OFS_CONTROL, 32'h0, '1);
        // ----------------------------------------
        // Break detect and send
        // ----------------------------------------
        wr(OFS_STATUS_TWO, 32'h2);
        i_sciu_node.send(16'h0400, 11, 1'b0);
        rc("no_brk", OFS_STATUS_TWO, 32'h0, 32'h80);
        i_sciu_node.send(16'h8000, 16, 1'b0);
        rc("brk", OFS_STATUS_TWO, 32'h80, 32'h80);
        rc("no_frame", OFS_STATUS_ONE, 32'h0, 32'h22);
        wr(OFS_STATUS_TWO, 32'h82);
        rc("brk_clr", OFS_STATUS_TWO, 32'h0, 32'h80);
        wr(OFS_STATUS_TWO, 32'h0);
        repeat (3)
        begin
            apb(OFS_STATUS_ONE, 1'b0, 32'h0);
            apb(OFS_DATA, 1'b0, 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_STATUS_TWO, {29'h0, i[0], 2'h0});
            wr(OFS_CONTROL, {27'h0, 1'b1, 1'b0, i[1], 2'h0});
            for (int n = 0; n < 200 && txd !== 1'b1; n++)
                @(posedge pclk);
            @(posedge pclk);
            compares++;
            if (i_sciu_node.brk_len != 8 * ((i[0] ? 13 : 10) + i[1]))
            begin
                fail_count++;
                $display("ERROR brk_len expected %0d seen %0d", 8 * ((i[0] ? 13 : 10) + i[1]),
                    i_sciu_node.brk_len);
            end
        end
        wr(OFS_CONTROL, 32'h0);
        // ----------------------------------------
        // Inverted receive line
        // ----------------------------------------
        wr(OFS_STATUS_TWO, 32'h50);
        i_sciu_node.send(16'h0001, 1, 1'b1);
        rc("inv_quiet", OFS_STATUS_TWO, 32'h10, 32'h70);
        apb(OFS_STATUS_ONE, 1'b0, 32'h0);
        apb(OFS_DATA, 1'b0, 32'h0);
        i_sciu_node.send({6'h3f, 1'b1, 8'h5a, 1'b0}, 10, 1'b1);
        rc("inv_full", OFS_STATUS_ONE, 32'h20, 32'h2b);
        rc("inv_data", OFS_DATA, 32'h5a, 32'hff);
        rc("inv_edge", OFS_STATUS_TWO, 32'h50, 32'h70);
        end_sim();
    end
endmodule : sciu_top_bench
